/* File: pss_pkg.sv */
// shared constants and types for the program sequencer and stack
// Overview of operation
// RULE1: jump loads program counter bits 8..0 from the instruction target field.
// RULE2: jump takes program counter bits 10..9 from status bits 6..5.
// RULE3: page select writes page bits in one cycle, operand limited to 0..3.
// RULE4: call pushes program counter plus one onto stack level one.
// RULE5: call loads counter bits 7..0 from target, forces bit 8 to zero.
// RULE6: call copies status page bits into counter bits 10..9.
// RULE7: eight-level hardware return address stack for subroutine nesting.
// RULE8: push shifts every level down, level one takes new address, eight lost.
// RULE9: return loads counter from level one, levels shift up, eight kept.
// RULE10: plain exit leaves accumulator; page variant also updates page bits.
// RULE11: interrupt exit with accumulator pops and adds accumulator to counter register.
// RULE12: literal exit pops and loads immediate constant into accumulator.
// RULE13: decrement/increment skip zero and bit tests skip next when true.
// RULE14: taken skip followed by page or bank skips both, three cycles.
// RULE15: chained page/bank after taken skip all skipped, one cycle each.
// RULE16: and, or, xor of accumulator with direct or indirect file register.
// RULE17: rotate file register left and right through carry.
// RULE18: complement file register or accumulator; nibble-swapped move into accumulator.
// RULE19: status holds carry, digit carry, zero, power down, timeout, page bits.
// RULE20: counter low byte at file 02h, status 03h, indirect pointer 04h.
// RULE21: file register operands address the space 00h to FFh.
// RULE22: jumps, calls and taken skips take extra cycles to refill pipeline; code does not refill on a taken skip, it only voids the next slot.
// RULE23: undivided clock branches take three clock cycles.
// RULE24: stack entries are eleven bits wide like the program counter.
// RULE25: page select changes only page bits, flags untouched.
package pss_pkg;

	localparam int PC_W = 11;
	localparam int STACK_DEPTH = 8;
	localparam int FILE_DEPTH = 256;
	localparam int BRANCH_CLKS = 3;
	localparam logic [1:0] BRANCH_WAIT = 2'(BRANCH_CLKS - 1);

	// status bit positions
	localparam int ST_CARRY = 0;
	localparam int ST_DCARRY = 1;
	localparam int ST_ZERO = 2;
	localparam int ST_PDOWN = 3;
	localparam int ST_WDOG = 4;
	localparam int ST_PAGE_LO = 5;
	localparam int ST_PAGE_HI = 6;
	localparam int PTR_BANK_LO = 5;

	// file space aliases
	localparam logic [7:0] FA_INDIRECT = 8'h00;
	localparam logic [7:0] FA_RTC = 8'h01;
	localparam logic [7:0] FA_PC_LOW = 8'h02;
	localparam logic [7:0] FA_STATUS = 8'h03;
	localparam logic [7:0] FA_POINTER = 8'h04;

	// bus register indexes, byte address is four times the index
	localparam logic [5:0] IDX_PC_LOW = 6'h02;
	localparam logic [5:0] IDX_STATUS = 6'h03;
	localparam logic [5:0] IDX_POINTER = 6'h04;
	localparam logic [5:0] IDX_CTRL = 6'h08;
	localparam logic [5:0] IDX_ACC = 6'h09;
	localparam int CTRL_RUN = 0;

	localparam logic [PC_W-1:0] PC_RST = 11'h000;
	localparam logic [7:0] STATUS_RST = 8'h18;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h01;
	localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

	typedef enum logic [4:0] {
		OP_NOP = 5'b00000,
		OP_JUMP = 5'b00001,
		OP_CALL = 5'b00010,
		OP_PAGE = 5'b00011,
		OP_BANK = 5'b00100,
		OP_SUB_EXIT = 5'b00101,
		OP_EXIT_WITH_PAGE = 5'b00110,
		OP_INTERRUPT_EXIT = 5'b00111,
		OP_INTERRUPT_EXIT_ADD_ACC = 5'b01000,
		OP_EXIT_LOAD_LITERAL = 5'b01001,
		OP_DEC_SKIP_ZERO = 5'b01010,
		OP_INC_SKIP_ZERO = 5'b01011,
		OP_SKIP_IF_SET = 5'b01100,
		OP_SKIP_IF_CLEAR = 5'b01101,
		OP_AND = 5'b01110,
		OP_OR = 5'b01111,
		OP_XOR = 5'b10000,
		OP_ROT_LEFT = 5'b10001,
		OP_ROT_RIGHT = 5'b10010,
		OP_NOT_FILE = 5'b10011,
		OP_NOT_ACC = 5'b10100,
		OP_SWAP_TO_ACC = 5'b10101
	} pss_op_t;

	typedef struct packed {
		pss_op_t op;
		logic [8:0] target;
		logic [7:0] file_reg_operand;
		logic [2:0] bit_sel;
		logic [7:0] literal;
		logic to_file;
	} pss_instr_t;

	typedef struct packed {
		logic read;
		logic write;
		logic [7:0] address;
		logic [31:0] writedata;
	} pss_avm_req_t;

endpackage : pss_pkg

/* File: pss_sequencer.sv */
// program sequencer, return stack, file datapath and register slave
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
module pss_sequencer (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic instr_valid_i,
	input wire pss_pkg::pss_instr_t instr_i,
	output logic instr_ready_o,
	output logic flush_o,
	output logic [pss_pkg::PC_W-1:0] fetch_pc_o,
	output logic [7:0] acc_o,
	input wire pss_pkg::pss_avm_req_t avm_i,
	output logic [31:0] avm_readdata_o,
	output logic avm_waitrequest_o
);
	import pss_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// state

	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] pc_d;
	logic [PC_W-1:0] stack_q [STACK_DEPTH];
	logic [7:0] file_q [FILE_DEPTH];
	logic [7:0] status_q;
	logic [7:0] pointer_q;
	logic [7:0] acc_q;
	logic [7:0] ctrl_q;
	logic ready_q;
	logic flush_q;
	logic [1:0] wait_q;
	logic skip_q;
	logic ack_q;
	logic waitreq_q;
	logic [31:0] rdata_q;

	logic fire;
	logic exec;
	logic [7:0] eff_addr;
	logic [7:0] opnd;
	logic [7:0] res;
	logic wr_file;
	logic wr_acc;
	logic [7:0] new_status;
	logic take_skip;
	logic branch;
	logic push;
	logic pop;
	logic [PC_W-1:0] pc_inc;
	logic bus_wr;
	logic [5:0] bus_idx;
	logic bus_aligned;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// reads alias the mapped core registers over the plain file array
	function automatic logic [7:0] file_rd(input logic [7:0] a);
		logic [7:0] v;
		v = file_q[a];
		case (a)
			FA_PC_LOW: v = pc_q[7:0]; // see RULE20
			FA_STATUS: v = status_q;
			FA_POINTER: v = pointer_q;
			default: v = file_q[a];
		endcase
		return v;
	endfunction : file_rd

	function automatic logic is_prefix(input pss_op_t o);
		return (o == OP_PAGE) || (o == OP_BANK);
	endfunction : is_prefix

	function automatic logic is_return(input pss_op_t o);
		return (o == OP_SUB_EXIT) || (o == OP_EXIT_WITH_PAGE) ||
			(o == OP_INTERRUPT_EXIT) || (o == OP_INTERRUPT_EXIT_ADD_ACC) ||
			(o == OP_EXIT_LOAD_LITERAL);
	endfunction : is_return

	////////////////////////////////////////////////////////////////////////
	// decode and datapath

	assign fire = instr_valid_i && ready_q && ctrl_q[CTRL_RUN];
	// a skipped slot still costs its cycle, which gives the chained count
	assign exec = fire && !skip_q; // see RULE14
	assign pc_inc = pc_q + 11'h001;
	// address zero goes through the pointer, the rest is direct
	assign eff_addr = (instr_i.file_reg_operand == FA_INDIRECT) ?
		pointer_q : instr_i.file_reg_operand; // see RULE16
	// a process, not an assign, so state read inside the helper wakes it
	always_comb
	begin
		opnd = file_rd(eff_addr); // see RULE21
	end

	always_comb
	begin
		res = opnd;
		wr_file = 1'b0;
		wr_acc = 1'b0;
		new_status = status_q;
		take_skip = 1'b0;
		case (instr_i.op)
			OP_AND, OP_OR, OP_XOR:
			begin
				case (instr_i.op)
					OP_AND: res = opnd & acc_q; // see RULE16
					OP_OR: res = opnd | acc_q;
					default: res = opnd ^ acc_q;
				endcase
				wr_file = instr_i.to_file;
				wr_acc = !instr_i.to_file;
				new_status[ST_ZERO] = (res == BYTE_RST);
			end
			OP_ROT_LEFT:
			begin
				res = {opnd[6:0], status_q[ST_CARRY]}; // see RULE17
				new_status[ST_CARRY] = opnd[7];
				wr_file = instr_i.to_file;
				wr_acc = !instr_i.to_file;
			end
			OP_ROT_RIGHT:
			begin
				res = {status_q[ST_CARRY], opnd[7:1]}; // see RULE17
				new_status[ST_CARRY] = opnd[0];
				wr_file = instr_i.to_file;
				wr_acc = !instr_i.to_file;
			end
			OP_NOT_FILE:
			begin
				res = ~opnd; // see RULE18
				wr_file = instr_i.to_file;
				wr_acc = !instr_i.to_file;
				new_status[ST_ZERO] = (res == BYTE_RST);
			end
			OP_NOT_ACC:
			begin
				res = ~acc_q; // see RULE18
				wr_acc = 1'b1;
				new_status[ST_ZERO] = (res == BYTE_RST);
			end
			OP_SWAP_TO_ACC:
			begin
				res = {opnd[3:0], opnd[7:4]}; // see RULE18
				wr_acc = 1'b1;
			end
			OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO:
			begin
				res = (instr_i.op == OP_DEC_SKIP_ZERO) ?
					opnd - 8'h01 : opnd + 8'h01;
				wr_file = 1'b1;
				take_skip = (res == BYTE_RST); // see RULE13
			end
			OP_SKIP_IF_SET: take_skip = opnd[instr_i.bit_sel]; // see RULE13
			OP_SKIP_IF_CLEAR: take_skip = !opnd[instr_i.bit_sel];
			OP_PAGE:
				// only two page bits exist in the operand, flags stay
				new_status[ST_PAGE_HI:ST_PAGE_LO] =
					instr_i.literal[1:0]; // see RULE3, RULE25
			OP_EXIT_WITH_PAGE:
				new_status[ST_PAGE_HI:ST_PAGE_LO] =
					stack_q[0][PC_W-1:PC_W-2]; // see RULE10
			OP_EXIT_LOAD_LITERAL:
			begin
				res = instr_i.literal; // see RULE12
				wr_acc = 1'b1;
			end
			OP_INTERRUPT_EXIT_ADD_ACC:
			begin
				res = file_q[FA_RTC] + acc_q; // see RULE11
			end
			default:
			begin
				res = opnd;
			end
		endcase
	end

	assign push = exec && (instr_i.op == OP_CALL);
	assign pop = exec && is_return(instr_i.op);
	assign branch = exec && ((instr_i.op == OP_JUMP) || push || pop ||
		(wr_file && (eff_addr == FA_PC_LOW)));

	always_comb
	begin
		pc_d = pc_inc;
		if (exec)
		begin
			case (instr_i.op)
				OP_JUMP:
					pc_d = {status_q[ST_PAGE_HI:ST_PAGE_LO],
						instr_i.target}; // see RULE1, RULE2
				OP_CALL:
					pc_d = {status_q[ST_PAGE_HI:ST_PAGE_LO], 1'b0,
						instr_i.target[7:0]}; // see RULE5, RULE6
				default:
				begin
					if (pop)
						pc_d = stack_q[0]; // see RULE9
					else if (wr_file && (eff_addr == FA_PC_LOW))
						pc_d = {pc_q[PC_W-1:8], res};
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program counter, pipeline refill and skip

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pc_q <= PC_RST;
		else if (bus_wr && (bus_idx == IDX_PC_LOW))
			pc_q <= {pc_q[PC_W-1:8], avm_i.writedata[7:0]};
		else if (fire)
			pc_q <= pc_d;
	end

	// a taken branch holds off the next slot for the refill cycles
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			wait_q <= 2'b00;
			ready_q <= 1'b0;
			flush_q <= 1'b0;
		end
		else if (branch)
		begin
			wait_q <= BRANCH_WAIT; // see RULE22, RULE23
			ready_q <= 1'b0;
			flush_q <= 1'b1;
		end
		else if (wait_q != 2'b00)
		begin
			wait_q <= wait_q - 2'b01;
			ready_q <= (wait_q == 2'b01);
			flush_q <= (wait_q != 2'b01);
		end
		else
		begin
			ready_q <= 1'b1;
			flush_q <= 1'b0;
		end
	end

	// prefixes stay swallowed until a real instruction has been dropped
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			skip_q <= 1'b0;
		else if (fire && skip_q)
			skip_q <= is_prefix(instr_i.op); // see RULE14, RULE15
		else if (exec)
			skip_q <= take_skip; // see RULE13
	end

	////////////////////////////////////////////////////////////////////////
	// return address stack

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			for (int i = 0; i < STACK_DEPTH; i++)
				stack_q[i] <= PC_RST; // see RULE7, RULE24
		end
		else if (push)
		begin
			stack_q[0] <= pc_inc; // see RULE4, RULE8
			for (int i = 1; i < STACK_DEPTH; i++)
				stack_q[i] <= stack_q[i-1];
		end
		else if (pop)
		begin
			// the bottom level keeps its value and so appears twice
			for (int i = 0; i < STACK_DEPTH - 1; i++)
				stack_q[i] <= stack_q[i+1]; // see RULE9
		end
	end

	////////////////////////////////////////////////////////////////////////
	// file registers, status, pointer and accumulator

	// bus writes come last so software wins a same-cycle collision
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			status_q <= STATUS_RST;
			pointer_q <= BYTE_RST;
			acc_q <= BYTE_RST;
			for (int i = 0; i < FILE_DEPTH; i++)
				file_q[i] <= BYTE_RST;
		end
		else
		begin
			if (exec)
			begin
				status_q <= new_status; // see RULE19
				if (wr_acc)
					acc_q <= res; // see RULE10
				if (instr_i.op == OP_BANK)
					pointer_q[7:PTR_BANK_LO] <=
						instr_i.literal[7:PTR_BANK_LO];
				if (instr_i.op == OP_INTERRUPT_EXIT_ADD_ACC)
					file_q[FA_RTC] <= res; // see RULE11
				if (wr_file)
				begin
					case (eff_addr)
						FA_STATUS: status_q <= res; // see RULE20
						FA_POINTER: pointer_q <= res;
						FA_PC_LOW: ;
						default: file_q[eff_addr] <= res;
					endcase
				end
			end
			if (bus_wr && (bus_idx == IDX_STATUS))
				status_q <= avm_i.writedata[7:0];
			if (bus_wr && (bus_idx == IDX_POINTER))
				pointer_q <= avm_i.writedata[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// avalon register slave: one wait state, answer on the second edge

	assign bus_idx = avm_i.address[7:2];
	assign bus_aligned = (avm_i.address[1:0] == 2'b00);
	assign bus_wr = avm_i.write && ack_q && bus_aligned;

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			ack_q <= 1'b0;
			waitreq_q <= 1'b1;
		end
		else
		begin
			ack_q <= (avm_i.read || avm_i.write) && !ack_q;
			waitreq_q <= !((avm_i.read || avm_i.write) && !ack_q);
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			rdata_q <= RDATA_ZERO;
		else if (avm_i.read && !ack_q)
		begin
			rdata_q <= RDATA_ZERO;
			if (bus_aligned)
			begin
				case (bus_idx)
					IDX_PC_LOW: rdata_q[7:0] <= pc_q[7:0];
					IDX_STATUS: rdata_q[7:0] <= status_q;
					IDX_POINTER: rdata_q[7:0] <= pointer_q;
					IDX_CTRL: rdata_q[7:0] <= ctrl_q;
					IDX_ACC: rdata_q[7:0] <= acc_q;
					default: rdata_q <= RDATA_ZERO;
				endcase
			end
		end
	end

	// run bit gates instruction intake so software can freeze the core
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			ctrl_q <= CTRL_RST;
		else if (bus_wr && (bus_idx == IDX_CTRL))
			ctrl_q <= {7'h00, avm_i.writedata[CTRL_RUN]};
	end

	assign instr_ready_o = ready_q;
	assign flush_o = flush_q;
	assign fetch_pc_o = pc_q;
	assign acc_o = acc_q;
	assign avm_readdata_o = rdata_q;
	// idle reads as busy; low only in the cycle that completes a request
	assign avm_waitrequest_o = waitreq_q;

endmodule : pss_sequencer

/* File: pss_sequencer_assertions.sv */
// port-level checks for the program sequencer
`timescale 1ns/1ps
module pss_chk (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic instr_valid_i,
	input wire pss_pkg::pss_instr_t instr_i,
	input wire logic instr_ready_o,
	input wire logic flush_o,
	input wire logic [pss_pkg::PC_W-1:0] fetch_pc_o,
	input wire logic [7:0] acc_o,
	input wire pss_pkg::pss_avm_req_t avm_i,
	input wire logic [31:0] avm_readdata_o,
	input wire logic avm_waitrequest_o
);
	import pss_pkg::*;
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);
	logic skip_q;
	logic take;
	// run bit is hidden here; slots after any skip are left unchecked
	assign take = instr_valid_i && instr_ready_o && !skip_q;
	always_ff @(posedge sys_clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			skip_q <= 1'b0;
		else if (instr_valid_i && instr_ready_o)
			skip_q <= instr_i.op inside {OP_DEC_SKIP_ZERO, OP_INC_SKIP_ZERO,
				OP_SKIP_IF_SET, OP_SKIP_IF_CLEAR} ||
				(skip_q && instr_i.op inside {OP_PAGE, OP_BANK});
	end
	////////////////////////////////////////////////////////////
	property p_jump;
		take && instr_i.op == OP_JUMP |=>
			fetch_pc_o[8:0] == $past(instr_i.target);
	endproperty
	a_jump: assert property (p_jump) else $error("jump target");
	property p_refill;
		take && instr_i.op inside {OP_JUMP, OP_CALL, OP_SUB_EXIT} |=>
			(flush_o && !instr_ready_o)[*2] ##1 (instr_ready_o && !flush_o);
	endproperty
	a_refill: assert property (p_refill) else $error("refill");
	property p_call;
		take && instr_i.op == OP_CALL |=>
			fetch_pc_o[8:0] == {1'b0, $past(instr_i.target[7:0])};
	endproperty
	a_call: assert property (p_call) else $error("call target");
	property p_lit;
		take && instr_i.op == OP_EXIT_LOAD_LITERAL |=>
			acc_o == $past(instr_i.literal);
	endproperty
	a_lit: assert property (p_lit) else $error("literal exit");
	property p_not;
		take && instr_i.op == OP_NOT_ACC |=> acc_o == ~$past(acc_o);
	endproperty
	a_not: assert property (p_not) else $error("acc complement");
	property p_single;
		take && instr_i.op inside {OP_AND, OP_NOT_ACC, OP_PAGE} |=>
			instr_ready_o && fetch_pc_o == $past(fetch_pc_o) + 11'h001;
	endproperty
	a_single: assert property (p_single) else $error("one cycle");
	property p_hold;
		flush_o |-> !instr_ready_o;
	endproperty
	a_hold: assert property (p_hold) else $error("ready in flush");
	property p_ack;
		(avm_i.read || avm_i.write) && avm_waitrequest_o |=> !avm_waitrequest_o;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer late");
	property p_pulse;
		!avm_waitrequest_o |=> avm_waitrequest_o;
	endproperty
	a_pulse: assert property (p_pulse) else $error("waitrequest low long");
	property p_upper;
		avm_i.read && !avm_waitrequest_o |-> avm_readdata_o[31:8] == 24'h000000;
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits");
	c_jump: cover property (take && instr_i.op == OP_JUMP);
	c_call: cover property (take && instr_i.op == OP_CALL);
	c_skip: cover property (skip_q && instr_valid_i && instr_ready_o);
	c_read: cover property (avm_i.read && !avm_waitrequest_o);
endmodule : pss_chk
bind pss_sequencer pss_chk u_chk (
	.sys_clk_i(sys_clk_i),
	.resetn_i(resetn_i),
	.instr_valid_i(instr_valid_i),
	.instr_i(instr_i),
	.instr_ready_o(instr_ready_o),
	.flush_o(flush_o),
	.fetch_pc_o(fetch_pc_o),
	.acc_o(acc_o),
	.avm_i(avm_i),
	.avm_readdata_o(avm_readdata_o),
	.avm_waitrequest_o(avm_waitrequest_o)
);

/* File: tb_program_sequencer_stack.sv */
// self-checking bench for the program sequencer
`timescale 1ns/1ps
module tb_program_sequencer_stack;
	import pss_pkg::*;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic instr_valid_i = 1'b0;
	pss_instr_t instr_i = '0;
	pss_avm_req_t avm_i = '0;
	logic instr_ready_o;
	logic flush_o;
	logic [PC_W-1:0] fetch_pc_o;
	logic [7:0] acc_o;
	logic [31:0] avm_readdata_o;
	logic avm_waitrequest_o;
	int err_count = 0;
	int checks = 0;
	logic [18:0] noteq[$];
	logic [31:0] rdq[$];
	logic [PC_W-1:0] pc = PC_RST;
	logic [PC_W-1:0] stk[8];
	logic [1:0] page = 2'h0;
	logic [7:0] acc = 8'h00;
	logic [7:0] fr = 8'h00;
	logic [7:0] rtc = 8'h00;
	logic [7:0] ptr = 8'hA5;
	logic [7:0] lf = 8'h3E;
	logic cy = 1'b0;
	logic drop = 1'b0;
	logic took_q = 1'b0;
	pss_op_t rets[5] = '{OP_SUB_EXIT, OP_EXIT_LOAD_LITERAL, OP_EXIT_WITH_PAGE,
		OP_INTERRUPT_EXIT, OP_INTERRUPT_EXIT_ADD_ACC};
	pss_op_t lops[7] = '{OP_NOT_ACC, OP_OR, OP_AND, OP_XOR, OP_SWAP_TO_ACC,
		OP_ROT_LEFT, OP_ROT_RIGHT};

	pss_sequencer DUT (
		.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.instr_valid_i(instr_valid_i),
		.instr_i(instr_i),
		.instr_ready_o(instr_ready_o),
		.flush_o(flush_o),
		.fetch_pc_o(fetch_pc_o),
		.acc_o(acc_o),
		.avm_i(avm_i),
		.avm_readdata_o(avm_readdata_o),
		.avm_waitrequest_o(avm_waitrequest_o)
	);

	always #2.5 sys_clk_i = ~sys_clk_i;
	////////////////////////////////////////////////////////////
	function automatic logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : nxt

	task automatic check(input string what, input logic [31:0] got,
		input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	// entered right after a clock edge; holds the request until answered
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] e);
		avm_i.read <= !wr;
		avm_i.write <= wr;
		avm_i.address <= a;
		avm_i.writedata <= d;
		if (!wr)
			rdq.push_back(e);
		do @(posedge sys_clk_i); while (avm_waitrequest_o);
		avm_i.read <= 1'b0;
		avm_i.write <= 1'b0;
		@(posedge sys_clk_i);
	endtask : bus

	// valid stays high between calls so issue is back to back
	task automatic ins(input pss_op_t op, input logic [8:0] t,
		input logic [7:0] f, input logic [2:0] b, input logic [7:0] l);
		logic [7:0] v;
		v = (f == 8'h04) ? ptr : (f == 8'h01) ? rtc : fr;
		pc = pc + 11'h001;
		if (drop)
			drop = op inside {OP_PAGE, OP_BANK};
		else
			case (op)
			OP_JUMP: pc = {page, t};
			OP_CALL:
			begin
				for (int k = 7; k > 0; k--) stk[k] = stk[k-1];
				stk[0] = pc;
				pc = {page, 1'b0, t[7:0]};
			end
			OP_PAGE: page = l[1:0];
			OP_BANK: ptr = {l[7:5], ptr[4:0]};
			OP_SUB_EXIT, OP_EXIT_WITH_PAGE, OP_INTERRUPT_EXIT,
			OP_INTERRUPT_EXIT_ADD_ACC, OP_EXIT_LOAD_LITERAL:
			begin
				pc = stk[0];
				for (int k = 0; k < 7; k++) stk[k] = stk[k+1];
				if (op == OP_EXIT_WITH_PAGE)
					page = pc[10:9];
				if (op == OP_EXIT_LOAD_LITERAL)
					acc = l;
				if (op == OP_INTERRUPT_EXIT_ADD_ACC)
					rtc = rtc + acc;
			end
			OP_INC_SKIP_ZERO: {drop, fr} = {v == 8'hFF, v + 8'h01};
			OP_DEC_SKIP_ZERO: {drop, fr} = {v == 8'h01, v - 8'h01};
			OP_SKIP_IF_SET: drop = v[b];
			OP_SKIP_IF_CLEAR: drop = !v[b];
			OP_AND: acc = acc & v;
			OP_OR: acc = acc | v;
			OP_XOR: acc = acc ^ v;
			OP_ROT_LEFT: {cy, acc} = {v, cy};
			OP_ROT_RIGHT: {acc, cy} = {cy, v};
			OP_NOT_FILE: fr = ~v;
			OP_NOT_ACC: acc = ~acc;
			OP_SWAP_TO_ACC: acc = {v[3:0], v[7:4]};
			default: ;
			endcase
		noteq.push_back({pc, acc});
		instr_valid_i <= 1'b1;
		instr_i <= '{op, t, f, b, l, op inside {OP_NOT_FILE, OP_INC_SKIP_ZERO,
			OP_DEC_SKIP_ZERO}};
		do @(posedge sys_clk_i); while (!instr_ready_o);
	endtask : ins

	task automatic idle;
		instr_valid_i <= 1'b0;
		@(posedge sys_clk_i);
	endtask : idle
	////////////////////////////////////////////////////////////
	always @(posedge sys_clk_i)
	begin
		if (took_q)
		begin
			check("pc", fetch_pc_o, noteq[0][18:8]);
			check("acc", acc_o, noteq[0][7:0]);
			void'(noteq.pop_front());
		end
		if (avm_i.read && !avm_waitrequest_o)
			check("readdata", avm_readdata_o, rdq.pop_front());
		took_q <= resetn_i && instr_valid_i && instr_ready_o;
	end

	initial
	begin
		repeat (30000) @(posedge sys_clk_i);
		err_count++;
		report_and_stop();
	end

	initial
	begin
		foreach (stk[k]) stk[k] = '0;
		repeat (16) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		@(posedge sys_clk_i);
		bus(0, 8'h0C, 0, 32'h18);
		bus(0, 8'h08, 0, 32'h0);
		bus(1, 8'h10, 32'hFFFFFFA5, 0);
		bus(0, 8'h10, 0, 32'hA5);
		bus(1, 8'h24, 32'h55, 0);
		bus(0, 8'h24, 0, 32'h0);
		bus(1, 8'hFC, 32'h77, 0);
		bus(0, 8'hFC, 0, 32'h0);
		bus(0, 8'h0E, 0, 32'h0);
		$display("test registers done");
		ins(OP_PAGE, 0, 0, 0, 8'h02);
		lf = nxt(lf);
		ins(OP_JUMP, {lf[0], lf}, 0, 0, 0);
		idle();
		bus(0, 8'h0C, 0, 32'h58);
		$display("test page jump done");
		ins(OP_PAGE, 0, 0, 0, 8'h01);
		for (int i = 0; i < 9; i++)
		begin
			lf = nxt(lf);
			ins(OP_CALL, {1'b1, lf}, 0, 0, 0);
		end
		for (int i = 0; i < 9; i++)
		begin
			lf = nxt(lf);
			ins(rets[i % 5], 0, 0, 0, lf);
		end
		ins(OP_SWAP_TO_ACC, 0, 8'h01, 0, 0);
		$display("test stack done");
		foreach (lops[i]) ins(lops[i], 0, 8'h04, 0, 0);
		ins(OP_BANK, 0, 0, 0, 8'h60);
		$display("test logic done");
		ins(OP_NOT_FILE, 0, 8'h10, 0, 0);
		ins(OP_INC_SKIP_ZERO, 0, 8'h10, 0, 0);
		ins(OP_PAGE, 0, 0, 0, 8'h03);
		ins(OP_BANK, 0, 0, 0, 8'hE0);
		ins(OP_JUMP, 9'h1F0, 0, 0, 0);
		ins(OP_NOT_ACC, 0, 0, 0, 0);
		ins(OP_DEC_SKIP_ZERO, 0, 8'h10, 0, 0);
		ins(OP_NOT_ACC, 0, 0, 0, 0);
		ins(OP_SKIP_IF_SET, 0, 8'h04, 3'h0, 0);
		ins(OP_NOT_ACC, 0, 0, 0, 0);
		ins(OP_SKIP_IF_CLEAR, 0, 8'h04, 3'h1, 0);
		ins(OP_CALL, 9'h0AA, 0, 0, 0);
		ins(OP_NOP, 0, 0, 0, 0);
		idle();
		bus(0, 8'h10, 0, {24'h0, ptr});
		bus(0, 8'h08, 0, {24'h0, pc[7:0]});
		$display("test skip done");
		repeat (4) @(posedge sys_clk_i);
		report_and_stop();
	end
endmodule : tb_program_sequencer_stack
